// ---- alarm_led_state_encoder.sv ----
// front-panel led and open-drain alarm encoder for a rectifier
// assumes condition inputs are asynchronous active-high levels and the
// register port master runs on core_clk
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "alarm_params.svh"

module alarm_led_state_encoder #(
   parameter int unsigned BLINK_HALF_CYC = `BLINK_HALF_CYC
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic input_present,
   input wire logic input_in_limits,
   input wire logic boost_decayed,
   input wire logic thermal_warn,
   input wire logic thermal_shutdown,
   input wire logic fan_fail,
   input wire logic fuse_blown,
   input wire logic boost_fail,
   input wire logic ov_latched,
   input wire logic overload,
   input wire logic standby,
   input wire logic internal_fault,
   input wire logic service_req,
   input wire logic comm_loss,
   input wire logic [3:0] alarm_od_in,
   output logic led_input_ok,
   output logic led_output_ok,
   output logic led_service,
   output logic led_fault,
   output logic [3:0] alarm_od_out,
   output logic [3:0] alarm_od_oe,
   output logic irq
);

   // ----------------------------------------
   // pin synchroniser and blink source
   // ----------------------------------------
   cond_sync_if syn ();
   logic blink_on;
   logic [`COND_W-1:0] c;

   // gather all asynchronous pins into one vector
   assign syn.raw = {alarm_od_in, comm_loss, service_req, internal_fault,
      standby, overload, ov_latched, boost_fail, fuse_blown, fan_fail,
      thermal_shutdown, thermal_warn, boost_decayed, input_in_limits,
      input_present};
   assign c = syn.sync[`COND_W-1:0];

   cond_sync u_sync (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .sif(syn)
   );

   blink_gen #(.HALF_CYC(BLINK_HALF_CYC)) u_blink (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .blink_on(blink_on)
   );

   // ----------------------------------------
   // condition priority
   // ----------------------------------------
   // power loss outranks everything since the leds cannot be trusted then
   function automatic alarm_pkg::cond_e classify(
      input logic [`COND_W-1:0] cv,
      input alarm_pkg::mode_e m
   );
      alarm_pkg::cond_e s;
      if (!cv[`CB_IN_PRESENT]) s = alarm_pkg::C_NO_INPUT;
      else if (!cv[`CB_IN_LIMITS]) s = alarm_pkg::C_OUT_LIMITS;
      else if (cv[`CB_THERM_SHUT]) s = alarm_pkg::C_THERM_SHUT;
      else if (cv[`CB_FAN_FAIL] || cv[`CB_FUSE_BLOWN] ||
               cv[`CB_BOOST_FAIL] || cv[`CB_OV_LATCHED])
         s = alarm_pkg::C_HARD_FAULT;
      else if (cv[`CB_THERM_WARN]) s = alarm_pkg::C_THERM_WARN;
      else if (cv[`CB_OVERLOAD]) s = alarm_pkg::C_OVERLOAD;
      else if (cv[`CB_STANDBY]) s = alarm_pkg::C_STANDBY;
      else if (cv[`CB_SOFT_FAULT]) s = alarm_pkg::C_SOFT_FAULT;
      else if (m == alarm_pkg::MODE_DIFF && cv[`CB_COMM_LOSS])
         s = alarm_pkg::C_COMM_LOSS;
      else if (m == alarm_pkg::MODE_TWO_WIRE && cv[`CB_SERVICE_REQ])
         s = alarm_pkg::C_SERVICE;
      else s = alarm_pkg::C_OK;
      return s;
   endfunction : classify

   // ----------------------------------------
   // state record
   // ----------------------------------------
   alarm_pkg::top_s r_reg;
   alarm_pkg::top_s r_next;
   logic [3:0] ev;

   // led and alarm encoding, events, register port
   always_comb begin
      r_next = r_reg;
      r_next.state = classify(c, r_reg.mode);
      r_next.od_out = 4'h0;           // open drain: only ever pulls low
      r_next.led_input_ok = 1'b1;
      r_next.led_output_ok = 1'b1;
      r_next.led_service = 1'b0;
      r_next.led_fault = 1'b0;
      r_next.od_oe = 4'h0;
      r_next.od_oe[`OD_PRESENT] = 1'b1;
      case (r_next.state)
         alarm_pkg::C_NO_INPUT: begin
            r_next.led_input_ok = 1'b0;
            r_next.led_output_ok = 1'b0;
            r_next.od_oe[`OD_PFAIL] = 1'b1;
         end
         alarm_pkg::C_OUT_LIMITS: begin
            r_next.led_input_ok = blink_on;
            r_next.led_output_ok = 1'b0;
            // power-fail tracks the boost rail, not the input window
            r_next.od_oe[`OD_PFAIL] = c[`CB_BOOST_DECAY];
         end
         alarm_pkg::C_THERM_SHUT: begin
            r_next.led_output_ok = 1'b0;
            r_next.led_service = 1'b1;
            r_next.led_fault = 1'b1;
            r_next.od_oe[`OD_FAULT] = 1'b1;
            r_next.od_oe[`OD_OTW] = 1'b1;
            r_next.od_oe[`OD_PFAIL] = 1'b1;
         end
         alarm_pkg::C_HARD_FAULT: begin
            r_next.led_output_ok = 1'b0;
            r_next.led_fault = 1'b1;
            r_next.od_oe[`OD_FAULT] = 1'b1;
            r_next.od_oe[`OD_PFAIL] = 1'b1;
         end
         alarm_pkg::C_THERM_WARN: begin
            r_next.led_service = 1'b1;
            r_next.od_oe[`OD_OTW] = 1'b1;
         end
         alarm_pkg::C_OVERLOAD: begin
            r_next.led_output_ok = blink_on;
            r_next.od_oe[`OD_PFAIL] = 1'b1;
         end
         alarm_pkg::C_STANDBY: begin
            r_next.led_output_ok = 1'b0;
            r_next.od_oe[`OD_PFAIL] = 1'b1;
         end
         alarm_pkg::C_SOFT_FAULT: begin
            r_next.led_fault = 1'b1;
            r_next.od_oe[`OD_FAULT] = 1'b1;
         end
         alarm_pkg::C_COMM_LOSS: begin
            r_next.led_fault = blink_on;
         end
         alarm_pkg::C_SERVICE: begin
            r_next.led_service = blink_on;
         end
         default: begin
            r_next.led_fault = 1'b0;
         end
      endcase

      // events: state change and the fault, otw and power-fail lines going low
      ev = 4'h0;
      ev[`EV_CHANGE] = (r_next.state != r_reg.state);
      ev[`EV_FAULT] = r_next.od_oe[`OD_FAULT] & ~r_reg.od_oe[`OD_FAULT];
      ev[`EV_OTW] = r_next.od_oe[`OD_OTW] & ~r_reg.od_oe[`OD_OTW];
      ev[`EV_PFAIL] = r_next.od_oe[`OD_PFAIL] & ~r_reg.od_oe[`OD_PFAIL];

      // register writes; status is read-only
      if (reg_wr && reg_addr == `REG_CTRL) begin
         r_next.mode = alarm_pkg::mode_e'(reg_wdata[1:0]);
      end
      if (reg_wr && reg_addr == `REG_MASK) begin
         r_next.mask = reg_wdata[3:0];
      end

      // read data stands for one cycle only; unmapped reads give zero
      r_next.rdata = 32'h0;
      if (reg_rd) begin
         case (reg_addr)
            `REG_CTRL: r_next.rdata[1:0] = r_reg.mode;
            `REG_STATUS: r_next.rdata[3:0] = r_reg.status;
            `REG_MASK: r_next.rdata[3:0] = r_reg.mask;
            `REG_COND: begin
               r_next.rdata[`COND_W-1:0] = c;
               r_next.rdata[`RB_OD_LSB +: 4] = syn.sync[`SYNC_W-1 -: 4];
               r_next.rdata[`RB_STATE_LSB +: 4] = r_reg.state;
            end
            default: r_next.rdata = 32'h0;
         endcase
      end

      // read clears what was seen; a new event in the same cycle survives
      if (reg_rd && reg_addr == `REG_STATUS) begin
         r_next.status = (r_reg.status & ~r_reg.status) | ev;
      end else begin
         r_next.status = r_reg.status | ev;
      end
      r_next.irq = |(r_next.status & r_next.mask);
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   // ----------------------------------------
   // outputs, all from the state record
   // ----------------------------------------
   assign reg_rdata = r_reg.rdata;
   assign led_input_ok = r_reg.led_input_ok;
   assign led_output_ok = r_reg.led_output_ok;
   assign led_service = r_reg.led_service;
   assign led_fault = r_reg.led_fault;
   assign alarm_od_out = r_reg.od_out;
   assign alarm_od_oe = r_reg.od_oe;
   assign irq = r_reg.irq;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   a_therm_warn_out: assert property (
      c[`CB_THERM_WARN] && c[`CB_IN_PRESENT] && c[`CB_IN_LIMITS] &&
      !c[`CB_THERM_SHUT] && !c[`CB_FAN_FAIL] && !c[`CB_FUSE_BLOWN] &&
      !c[`CB_BOOST_FAIL] && !c[`CB_OV_LATCHED]
      |=> led_input_ok && led_output_ok && led_service && !led_fault &&
      alarm_od_oe[2:0] == 3'h2)
      else $error("thermal warning pattern wrong");

   a_hard_fault_out: assert property (
      r_reg.state == alarm_pkg::C_HARD_FAULT |->
      {led_input_ok, led_output_ok, led_service, led_fault} == 4'h9 &&
      alarm_od_oe[2:0] == 3'h5)
      else $error("hard fault pattern wrong");

   a_limits_blink: assert property (
      r_next.state == alarm_pkg::C_OUT_LIMITS |=>
      led_input_ok == $past(blink_on) && !led_output_ok && !led_service &&
      !led_fault && alarm_od_oe[1:0] == 2'h0)
      else $error("out of limits pattern wrong");

   a_pfail_boost_track: assert property (
      r_reg.state == alarm_pkg::C_OUT_LIMITS |->
      alarm_od_oe[`OD_PFAIL] == $past(c[`CB_BOOST_DECAY]))
      else $error("power-fail line not following boost rail");

   // the record is still held in reset at the edge that releases it
   a_no_input_out: assert property (
      reset_n && !c[`CB_IN_PRESENT] |=>
      {led_input_ok, led_output_ok, led_service, led_fault} == 4'h0 &&
      alarm_od_oe[2:0] == 3'h4)
      else $error("no input pattern wrong");

   a_soft_fault_out: assert property (
      r_reg.state == alarm_pkg::C_SOFT_FAULT |->
      led_input_ok && led_output_ok && !led_service && led_fault &&
      alarm_od_oe[2:0] == 3'h1)
      else $error("soft fault pattern wrong");

   a_service_blink: assert property (
      r_next.state == alarm_pkg::C_SERVICE |=>
      led_service == $past(blink_on) && led_input_ok && led_output_ok &&
      !led_fault && alarm_od_oe[2:0] == 3'h0)
      else $error("service blink pattern wrong");

   a_comm_loss_blink: assert property (
      r_next.state == alarm_pkg::C_COMM_LOSS |=>
      led_fault == $past(blink_on) && led_input_ok && led_output_ok &&
      !led_service && alarm_od_oe[2:0] == 3'h0)
      else $error("comms loss pattern wrong");

   a_ok_present_low: assert property (
      $past(reset_n) && r_reg.state == alarm_pkg::C_OK |->
      {led_input_ok, led_output_ok, led_service, led_fault} == 4'hC &&
      alarm_od_oe == 4'h8 && alarm_od_out == 4'h0)
      else $error("ok pattern or present line wrong");

   a_therm_shut_out: assert property (
      r_reg.state == alarm_pkg::C_THERM_SHUT |->
      {led_input_ok, led_output_ok, led_service, led_fault} == 4'hB &&
      alarm_od_oe == 4'hF)
      else $error("thermal shutdown pattern wrong");

   a_status_irq_link: assert property (
      irq == |(r_reg.status & r_reg.mask))
      else $error("irq does not match status and mask");

   c_service_seen: cover property (r_reg.state == alarm_pkg::C_SERVICE);
   c_comm_loss_seen: cover property (r_reg.state == alarm_pkg::C_COMM_LOSS);
   c_shut_to_ok: cover property (
      r_reg.state == alarm_pkg::C_THERM_SHUT ##[1:50]
      r_reg.state == alarm_pkg::C_OK);
   c_irq_raised: cover property ($rose(irq));

endmodule : alarm_led_state_encoder

`default_nettype wire

// ---- alarm_params.svh ----
// constants for the alarm and led state encoder
// assumes a 40 MHz core clock and 32-bit register words
`ifndef ALARM_PARAMS_SVH
`define ALARM_PARAMS_SVH

// register offsets (byte addresses)
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_MASK 8'h08
`define REG_COND 8'h0C

// reset values
`define CTRL_RST 2'h0
`define MASK_RST 4'h0

// status and mask bit positions
`define EV_CHANGE 0
`define EV_FAULT 1
`define EV_OTW 2
`define EV_PFAIL 3

// open-drain alarm vector bit positions
`define OD_FAULT 0
`define OD_OTW 1
`define OD_PFAIL 2
`define OD_PRESENT 3

// condition vector bit positions
`define CB_IN_PRESENT 0
`define CB_IN_LIMITS 1
`define CB_BOOST_DECAY 2
`define CB_THERM_WARN 3
`define CB_THERM_SHUT 4
`define CB_FAN_FAIL 5
`define CB_FUSE_BLOWN 6
`define CB_BOOST_FAIL 7
`define CB_OV_LATCHED 8
`define CB_OVERLOAD 9
`define CB_STANDBY 10
`define CB_SOFT_FAULT 11
`define CB_SERVICE_REQ 12
`define CB_COMM_LOSS 13
`define COND_W 14
`define SYNC_W 18

// cond readback field positions
`define RB_OD_LSB 14
`define RB_STATE_LSB 20

// blink timing
`define CLK_KHZ 40000
`define BLINK_HALF_MS 250
`define BLINK_HALF_CYC (`BLINK_HALF_MS * `CLK_KHZ)
`define BLINK_CNT_W 24

`endif

// ---- alarm_pkg.sv ----
// types shared by the alarm and led state encoder modules
// assumes alarm_params.svh is on the include path
`include "alarm_params.svh"

package alarm_pkg;

   // ----------------------------------------
   // condition and protocol mode encodings
   // ----------------------------------------
   typedef enum logic [3:0] {
      C_OK, C_NO_INPUT, C_OUT_LIMITS, C_THERM_SHUT, C_HARD_FAULT,
      C_THERM_WARN, C_OVERLOAD, C_STANDBY, C_SOFT_FAULT, C_COMM_LOSS,
      C_SERVICE
   } cond_e;

   typedef enum logic [1:0] {MODE_ANALOG, MODE_TWO_WIRE, MODE_DIFF} mode_e;

   // ----------------------------------------
   // module state records
   // ----------------------------------------
   typedef struct packed {
      logic [`SYNC_W-1:0] meta;
      logic [`SYNC_W-1:0] stable;
   } sync_s;

   typedef struct packed {
      logic [`BLINK_CNT_W-1:0] cnt;
      logic phase;
   } blink_s;

   typedef struct packed {
      mode_e mode;
      logic [3:0] status;
      logic [3:0] mask;
      cond_e state;
      logic led_input_ok;
      logic led_output_ok;
      logic led_service;
      logic led_fault;
      logic [3:0] od_out;
      logic [3:0] od_oe;
      logic irq;
      logic [31:0] rdata;
   } top_s;

endpackage : alarm_pkg

// ---- cond_sync_if.sv ----
// carrier between the pin synchroniser and the encoder
// assumes both ends run on core_clk
`timescale 1ns/1ps
`default_nettype none
`include "alarm_params.svh"

interface cond_sync_if;
   logic [`SYNC_W-1:0] raw;
   logic [`SYNC_W-1:0] sync;
   modport sync_side (input raw, output sync);
   modport user (output raw, input sync);
endinterface : cond_sync_if

`default_nettype wire

// ---- cond_sync.sv ----
// two-flop synchroniser for the condition and alarm readback pins
// assumes raw inputs are asynchronous levels
`timescale 1ns/1ps
`default_nettype none
`include "alarm_params.svh"

module cond_sync (
   input wire logic core_clk,
   input wire logic reset_n,
   cond_sync_if.sync_side sif
);

   alarm_pkg::sync_s r_reg;
   alarm_pkg::sync_s r_next;

   // meta feeds only the stable stage
   always_comb begin
      r_next = r_reg;
      r_next.meta = sif.raw;
      r_next.stable = r_reg.meta;
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign sif.sync = r_reg.stable;

endmodule : cond_sync

`default_nettype wire

// ---- blink_gen.sv ----
// square-wave blink phase for the flashing led states
// assumes half_cyc is at least 2
`timescale 1ns/1ps
`default_nettype none
`include "alarm_params.svh"

module blink_gen #(
   parameter int unsigned HALF_CYC = `BLINK_HALF_CYC
) (
   input wire logic core_clk,
   input wire logic reset_n,
   output logic blink_on
);

   alarm_pkg::blink_s r_reg;
   alarm_pkg::blink_s r_next;

   // free-running counter; phase flips every half period
   always_comb begin
      r_next = r_reg;
      if (r_reg.cnt == `BLINK_CNT_W'(HALF_CYC - 1)) begin
         r_next.cnt = '0;
         r_next.phase = ~r_reg.phase;
      end else begin
         r_next.cnt = r_reg.cnt + `BLINK_CNT_W'(1);
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign blink_on = r_reg.phase;

endmodule : blink_gen

`default_nettype wire

// ---- shelf_monitor.sv ----
// model of the shelf controller side of the open-drain alarm lines
// assumes one pull-up resistor per line and od_oe high while pulled low
`timescale 1ns/1ps
`default_nettype none

module shelf_monitor (
   input wire logic core_clk,
   input wire logic [3:0] od_out,
   input wire logic [3:0] od_oe,
   output logic [3:0] line,
   output logic [3:0] seen
);

   // ----------------------------------------
   // wire levels
   // ----------------------------------------
   // a released line floats up to the pull-up, never the last value
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         line[i] = od_oe[i] ? od_out[i] : 1'b1;
      end
   end

   // controller samples the lines on the core_clk rising edge
   always_ff @(posedge core_clk) begin
      seen <= line;
   end

endmodule : shelf_monitor

`default_nettype wire

// ---- testbench.sv ----
// self-checking bench for the alarm and led state encoder
// assumes shelf_monitor closes the open-drain loop back into the design
`timescale 1ns/1ps
`default_nettype none
`include "alarm_params.svh"

module testbench;

   logic core_clk;
   logic reset_n;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [31:0] reg_rdata;
   logic [13:0] cv;
   logic [3:0] leds;
   logic [3:0] od_out;
   logic [3:0] od_oe;
   logic [3:0] line;
   logic [3:0] seen;
   logic irq;
   logic led_in, led_out, led_svc, led_flt;
   int errors;
   int n_tests;
   int cycles;
   integer seed;
   logic [31:0] d;
   logic [15:0] c;
   logic [15:0] hand [21];

   // ----------------------------------------
   // clock, design and partner
   // ----------------------------------------
   always #12.5 core_clk = ~core_clk;

   assign leds = {led_in, led_out, led_svc, led_flt};

   // short blink half period keeps the blink checks quick
   alarm_led_state_encoder #(.BLINK_HALF_CYC(4)) u_dut (
      .core_clk(core_clk), .reset_n(reset_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .input_present(cv[0]), .input_in_limits(cv[1]),
      .boost_decayed(cv[2]), .thermal_warn(cv[3]),
      .thermal_shutdown(cv[4]), .fan_fail(cv[5]), .fuse_blown(cv[6]),
      .boost_fail(cv[7]), .ov_latched(cv[8]), .overload(cv[9]),
      .standby(cv[10]), .internal_fault(cv[11]),
      .service_req(cv[12]), .comm_loss(cv[13]), .alarm_od_in(line),
      .led_input_ok(led_in), .led_output_ok(led_out),
      .led_service(led_svc), .led_fault(led_flt),
      .alarm_od_out(od_out), .alarm_od_oe(od_oe), .irq(irq)
   );

   shelf_monitor u_mon (
      .core_clk(core_clk), .od_out(od_out), .od_oe(od_oe),
      .line(line), .seen(seen)
   );

   // ----------------------------------------
   // expectation, compares and bus tasks
   // ----------------------------------------
   // {blink mask, steady leds in/out/svc/flt, pulled lines pwr/otw/flt}
   function automatic logic [10:0] exp_out(input logic [13:0] v,
                                           input logic [1:0] m);
      if (!v[0]) return 11'h004;                        // no input
      if (!v[1]) return {4'h8, 4'h0, v[2], 2'h0};       // out of limits
      if (v[4]) return 11'h05F;                         // shutdown
      if (|v[8:5]) return 11'h04D;                      // hard fault
      if (v[3]) return 11'h072;                         // thermal warn
      if (v[9]) return 11'h244;                         // overload
      if (v[10]) return 11'h044;                        // standby
      if (v[11]) return 11'h069;                        // internal fault
      if (v[13] && m == 2'h2) return 11'h0E0;           // comm loss
      if (v[12] && m == 2'h1) return 11'h160;           // service
      return 11'h060;
   endfunction : exp_out

   task automatic cmp_pin(input logic [3:0] got, input logic [3:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp_pin

   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp_word

   task automatic reg_write(input logic [7:0] a, input logic [31:0] w);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= w;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : reg_write

   // read data stand only in the cycle after the strobe edge
   task automatic reg_read(input logic [7:0] a, output logic [31:0] r);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 r = reg_rdata;
   endtask : reg_read

   // one condition set: 3 edges of latency, then 16 cycles = 2 blinks
   task automatic run_case(input logic [15:0] k);
      logic [10:0] e;
      logic [31:0] r;
      int ones;
      e = exp_out(k[13:0], k[15:14]);
      reg_write(`REG_CTRL, {30'h0, k[15:14]});
      @(posedge core_clk);
      cv <= k[13:0];
      repeat (4) @(posedge core_clk);
      ones = 0;
      for (int i = 0; i < 16; i++) begin
         @(posedge core_clk) #1;
         cmp_pin(leds&~e[10:7],e[6:3]);
         cmp_pin(line, {1'b0, ~e[2:0]});
         cmp_pin(seen, {1'b0, ~e[2:0]});
         cmp_pin({3'h0, irq}, 4'h0);
         if (|(leds & e[10:7])) ones++;
      end
      if (e[10:7] != 4'h0) cmp_word(ones, 32'h8);
      reg_read(`REG_COND, r);
      cmp_word(r & 32'h3FFFF, {14'h0, line, k[13:0]});
      $display("case %h done", k);
   endtask : run_case

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_sim

   // hang guard well above the ~1075 cycles the run needs
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 6000) begin
         errors++;
         end_sim();
      end
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      core_clk = 1'b0;
      reset_n = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      cv = 14'h0003;
      errors = 0;
      n_tests = 0;
      cycles = 0;
      seed = 9;
      // {mode, conditions}: every class, mode gating and priority corners
      hand = '{16'h0003, 16'h0000, 16'h3FFE, 16'h0001, 16'h0005,
               16'h0013, 16'h001B, 16'h0023, 16'h0043, 16'h0083,
               16'h0103, 16'h000B, 16'h0203, 16'h0403, 16'h0803,
               16'hA003, 16'h5003, 16'h1003, 16'h6003, 16'hD003,
               16'hB003};
      repeat (2) @(posedge core_clk);
      #1;
      cmp_pin(leds, 4'h0);
      cmp_pin(od_oe, 4'h0);
      cmp_word(reg_rdata, 32'h0);
      repeat (1) @(posedge core_clk);
      reset_n <= 1'b1;
      // reset values, unmapped read, ignored unmapped write
      reg_read(`REG_CTRL, d);
      cmp_word(d, 32'h0);
      reg_read(`REG_MASK, d);
      cmp_word(d, 32'h0);
      reg_write(8'h10, 32'hFFFFFFFF);
      reg_read(8'h10, d);
      cmp_word(d, 32'h0);
      $display("register test done");
      // interrupt: masked event raises irq, status read clears it
      run_case(16'h0003);
      reg_write(`REG_MASK, 32'h4);
      reg_read(`REG_STATUS, d);
      @(posedge core_clk);
      cv <= 14'h000B;
      repeat (4) @(posedge core_clk);
      #1 cmp_pin({3'h0, irq}, 4'h1);
      reg_read(`REG_STATUS, d);
      cmp_word(d, 32'h5);
      @(posedge core_clk) #1;
      cmp_pin({3'h0, irq}, 4'h0);
      reg_write(`REG_MASK, 32'h0);
      $display("interrupt test done");
      for (int i = 0; i < 21; i++) run_case(hand[i]);
      // random conditions, biased towards a healthy input
      for (int i = 0; i < 20; i++) begin
         c = 16'($random(seed) & $random(seed));
         if (c[15]) c[1:0] = 2'h3;
         run_case(c);
      end
      end_sim();
   end

endmodule : testbench

`default_nettype wire
